// >>> ssd_pkg.sv
package ssd_pkg;

  // ****************************************************************
  // Link shape
  // ****************************************************************
  localparam int SYM_W      = 8;      // Bits per symbol
  localparam int SYM_N      = 4;      // Symbols per beat
  localparam int DATA_W     = SYM_W * SYM_N;
  localparam int CHAN_W     = 1;      // Channel signal width
  localparam int ERR_W      = 1;      // Error signal width
  localparam int MAX_CHAN   = 1;      // Highest channel number
  localparam int EMPTY_W    = 2;      // Holds 0..SYM_N-1
  localparam int READY_LAT  = 0;      // Ready to valid delay
  localparam int API_W      = 64;     // Call-side word width
  localparam int API_RET_W  = 64;     // Return-side word width

  // ****************************************************************
  // Build options
  // ****************************************************************
  localparam bit USE_PACKETS = 1'b0;
  localparam bit USE_EMPTY   = 1'b0;
  localparam bit USE_CHANNEL = 1'b1;
  localparam bit USE_ERROR   = 1'b1;
  localparam bit USE_READY   = 1'b1;
  localparam bit USE_VALID   = 1'b1;

  // ****************************************************************
  // Queues and counters
  // ****************************************************************
  localparam int Q_DEPTH = 8;         // Entries per queue
  localparam int Q_AW    = 3;         // Index width
  localparam int CNT_W   = 4;         // Occupancy width, 0..Q_DEPTH
  localparam int IDLE_W  = 16;        // Idle count width
  localparam int LAT_W   = 32;        // Latency and timeout width

  // ****************************************************************
  // Field selectors of the descriptor stage
  // ****************************************************************
  typedef enum logic [2:0] {
    SSD_F_DATA  = 3'h0,
    SSD_F_CHAN  = 3'h1,
    SSD_F_ERR   = 3'h2,
    SSD_F_EMPTY = 3'h3,
    SSD_F_SOP   = 3'h4,
    SSD_F_EOP   = 3'h5,
    SSD_F_IDLES = 3'h6
  } ssd_field_e;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic [DATA_W-1:0]  data;
    logic [CHAN_W-1:0]  chan;
    logic [ERR_W-1:0]   err;
    logic [EMPTY_W-1:0] empty;
    logic               sop;
    logic               eop;
    logic [IDLE_W-1:0]  idles;
  } ssd_trans_s;

  typedef struct packed {
    logic               valid;
    logic [DATA_W-1:0]  data;
    logic [CHAN_W-1:0]  chan;
    logic [ERR_W-1:0]   err;
    logic [EMPTY_W-1:0] empty;
    logic               sop;
    logic               eop;
  } ssd_link_s;

  typedef struct packed {
    logic drive;        // Started presenting valid data
    logic rdy_rise;     // Sink asserted ready
    logic rdy_fall;     // Sink deasserted ready
    logic done;         // Transaction completed
    logic timeout;      // Backpressure exceeded limit
    logic fatal;        // Unrecoverable error
  } ssd_events_s;

  typedef logic [LAT_W-1:0] ssd_lat_t;

endpackage : ssd_pkg

// >>> ssd_queue.sv
module ssd_queue #(
  parameter int W = 8                        // Entry width
) (
  input  wire logic                      clk,      // Clock
  input  wire logic                      rst,      // Sync reset
  input  wire logic                      clear,    // Empty the queue
  input  wire logic                      push,     // Write entry
  input  wire logic [W-1:0]              wdata,    // Entry to write
  input  wire logic                      pop,      // Drop head entry
  output logic      [W-1:0]              head,     // Head entry
  output logic                           full,     // No room
  output logic                           empty,    // Nothing held
  output logic      [ssd_pkg::CNT_W-1:0] count     // Entries held
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [ssd_pkg::Q_DEPTH-1:0][W-1:0] mem;
    logic [ssd_pkg::Q_AW-1:0]           wr;
    logic [ssd_pkg::Q_AW-1:0]           rd;
    logic [ssd_pkg::CNT_W-1:0]          cnt;
  } ssd_q_s;

  ssd_q_s q_reg;
  ssd_q_s q_next;
  logic   do_push;
  logic   do_pop;

  // Pointer and count update
  always_comb begin
    q_next  = q_reg;
    do_push = push && !full;
    do_pop  = pop && !empty;
    if (do_push) begin
      q_next.mem[q_reg.wr] = wdata;
      q_next.wr            = q_reg.wr + 1'b1;
    end
    if (do_pop) begin
      q_next.rd = q_reg.rd + 1'b1;
    end
    q_next.cnt = q_reg.cnt + ssd_pkg::CNT_W'(do_push) - ssd_pkg::CNT_W'(do_pop);
    if (clear) begin
      q_next.wr  = '0;
      q_next.rd  = '0;
      q_next.cnt = '0;
    end
  end

  // Registers
  always_ff @(posedge clk) begin
    if (rst) begin
      q_reg <= '0;
    end else begin
      q_reg <= q_next;
    end
  end

  // Flags
  assign head  = q_reg.mem[q_reg.rd];
  assign count = q_reg.cnt;
  assign empty = (q_reg.cnt == '0);
  assign full  = (q_reg.cnt == ssd_pkg::CNT_W'(ssd_pkg::Q_DEPTH));

endmodule : ssd_queue

// >>> ssd_sink_model.sv
module ssd_sink_model (
  input  wire logic               clk,        // Clock
  input  wire logic               rst,        // Sync reset
  input  wire ssd_pkg::ssd_link_s link,       // Beats from the source
  input  wire logic               hold_off,   // Stall request from bench
  output logic                    snk_ready   // Ready pin toward source
);
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // Ready pin and beat capture
  // ****************************************************************
  ssd_pkg::ssd_link_s got[$];
  logic               rdy_q1;
  logic               rdy_q2;

  // Ready is a plain level, stalled only while the bench asks
  assign snk_ready = !hold_off;

  // Same two-stage ready view as the source; a beat lands when valid meets it
  always @(posedge clk) begin
    if (rst) begin
      rdy_q1 <= 1'h0;
      rdy_q2 <= 1'h0;
    end else begin
      rdy_q1 <= snk_ready;
      rdy_q2 <= rdy_q1;
      if (link.valid === 1'h1 && rdy_q2) begin
        got.push_back(link);
      end
    end
  end
endmodule : ssd_sink_model

// >>> ssd_source.sv
// Overview of operation
// - Latency zero: hold the current beat unchanged until ready.
// - Latency above zero: drive idles until ready, then present the beat.
// - Let each transaction's idle count pass before driving it.
// - Record backpressure cycles per transaction; show latency of last popped response.
// - Pulse driving event when valid data for a transaction starts.
// - Pulse separate events on ready rising and ready falling.
// - Pulse complete event on finish; keep readable complete status bit.
// - Descriptor stage gathers fields, pushes completed command to pending queue.
// - Bus monitor reports ready state to driver and event logic.
// - Response queue collects completed transactions; its occupancy is readable.
// - Number of waiting transactions is readable at any time.
// - Ready input, as synchronised two cycles behind the pin, is readable as one bit.
// - Packet option adds sop, eop, empty; empty option adds empty alone.
// - Options independently keep or drop channel, error, ready and valid.
// - Beat is a parameterised count of symbols of parameterised width.
// - Channel width, error width and max channel are parameters of 1.
// - Ready latency is a parameter of 0 shared with the sink.
// - Protocol-illegal transactions are driven as asked, never blocked.
// - Wrapped variant call and return words are 64-bit parameters.
// - Programmable backpressure timeout raises an error; zero disables it.
// - Initialise command returns link outputs to idle.
// - Queued transactions are driven in order with their field settings; fields of disabled options go out as zero.
// - Fatal error event on unrecoverable error, then all activity stops.
module ssd_source (
  input  wire logic                            clk,           // Clock, 200 MHz
  input  wire logic                            rst,           // Sync reset
  input  wire logic                            init,          // Idle the link, flush
  input  wire logic                            field_we,      // Descriptor field write
  input  wire ssd_pkg::ssd_field_e             field_sel,     // Which field
  input  wire logic [ssd_pkg::DATA_W-1:0]      field_val,     // Field value
  input  wire logic                            push_trans,    // Queue descriptor
  input  wire logic                            pop_resp,      // Retire a response
  input  wire ssd_pkg::ssd_lat_t               resp_timeout,  // Backpressure limit, 0 off
  input  wire logic                            fatal_req,     // Unrecoverable error
  input  wire logic                            snk_ready,     // Sink ready pin
  output ssd_pkg::ssd_link_s                   link,          // Link outputs
  output ssd_pkg::ssd_events_s                 events,        // Event pulses
  output logic [ssd_pkg::CNT_W-1:0]            trans_count,   // Waiting transactions
  output logic [ssd_pkg::CNT_W-1:0]            resp_count,    // Held responses
  output ssd_pkg::ssd_lat_t                    resp_latency,  // Last popped latency
  output logic                                 ready_now,     // Ready seen by source
  output logic                                 trans_done,    // Complete status
  output logic                                 halted,        // Stopped after fatal
  output logic                                 trans_full     // Pending queue full
);

  // ****************************************************************
  // Types and state
  // ****************************************************************
  typedef enum logic [1:0] {
    SSD_IDLE = 2'b00,
    SSD_WAIT = 2'b01,
    SSD_SEND = 2'b11,
    SSD_STOP = 2'b10
  } ssd_st_e;

  typedef struct packed {
    ssd_st_e                  st;
    logic                     rdy_s1;
    logic                     rdy_s2;
    logic                     rdy_d;
    ssd_pkg::ssd_trans_s      desc;
    ssd_pkg::ssd_link_s       link;
    logic [ssd_pkg::IDLE_W-1:0] idle_cnt;
    ssd_pkg::ssd_lat_t        lat;
    ssd_pkg::ssd_lat_t        last_lat;
    ssd_pkg::ssd_events_s     ev;
    logic                     done;
  } ssd_state_s;

  ssd_state_s          s_reg;
  ssd_state_s          s_next;
  ssd_pkg::ssd_trans_s tq_head;
  logic                tq_empty;
  logic                tq_pop;
  ssd_pkg::ssd_lat_t   rq_head;
  logic                rq_full;
  logic                rq_empty;
  logic                rq_push;
  logic                ready_eff;
  logic                accept;
  logic                flush;

  // ****************************************************************
  // Queues
  // ****************************************************************
  // Pending transactions from the descriptor stage
  ssd_queue #(.W($bits(ssd_pkg::ssd_trans_s))) u_tq (
    .clk   (clk),
    .rst   (rst),
    .clear (flush),
    .push  (push_trans),
    .wdata (s_reg.desc),
    .pop   (tq_pop),
    .head  (tq_head),
    .full  (trans_full),
    .empty (tq_empty),
    .count (trans_count)
  );

  // Responses carry the backpressure latency
  ssd_queue #(.W(ssd_pkg::LAT_W)) u_rq (
    .clk   (clk),
    .rst   (rst),
    .clear (flush),
    .push  (rq_push),
    .wdata (s_reg.lat),
    .pop   (pop_resp),
    .head  (rq_head),
    .full  (rq_full),
    .empty (rq_empty),
    .count (resp_count)
  );

  // ****************************************************************
  // Bus monitor
  // ****************************************************************
  // Synchronised ready; absent ready pin reads as always ready
  assign ready_eff = ssd_pkg::USE_READY ? s_reg.rdy_s2 : 1'b1;
  assign ready_now = ready_eff;
  // Beat accepted: with latency, the beat is only sent once ready is seen
  assign accept    = (s_reg.st == SSD_SEND) && ready_eff;
  assign flush     = init || (s_reg.st == SSD_STOP);
  assign tq_pop    = accept && !rq_full;
  assign rq_push   = tq_pop;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    s_next        = s_reg;
    s_next.rdy_s1 = snk_ready;
    s_next.rdy_s2 = s_reg.rdy_s1;
    s_next.rdy_d  = ready_eff;
    s_next.ev     = '0;
    // Ready edge events
    s_next.ev.rdy_rise = ready_eff && !s_reg.rdy_d;
    s_next.ev.rdy_fall = !ready_eff && s_reg.rdy_d;
    // Descriptor stage gathers fields; no legality checks applied
    if (field_we) begin
      case (field_sel)
        ssd_pkg::SSD_F_DATA:  s_next.desc.data  = field_val;
        ssd_pkg::SSD_F_CHAN:  s_next.desc.chan  = field_val[ssd_pkg::CHAN_W-1:0];
        ssd_pkg::SSD_F_ERR:   s_next.desc.err   = field_val[ssd_pkg::ERR_W-1:0];
        ssd_pkg::SSD_F_EMPTY: s_next.desc.empty = field_val[ssd_pkg::EMPTY_W-1:0];
        ssd_pkg::SSD_F_SOP:   s_next.desc.sop   = field_val[0];
        ssd_pkg::SSD_F_EOP:   s_next.desc.eop   = field_val[0];
        ssd_pkg::SSD_F_IDLES: s_next.desc.idles = field_val[ssd_pkg::IDLE_W-1:0];
        default: ;
      endcase
    end
    if (pop_resp && !rq_empty) begin
      s_next.last_lat = rq_head;
    end
    case (s_reg.st)
      SSD_IDLE: begin
        s_next.link.valid = 1'b0;
        if (!tq_empty) begin
          s_next.idle_cnt = tq_head.idles;
          s_next.st       = SSD_WAIT;
          s_next.done     = 1'b0;
        end
      end
      SSD_WAIT: begin
        if (s_reg.idle_cnt != '0) begin
          s_next.idle_cnt = s_reg.idle_cnt - 1'b1;
        end else if (ssd_pkg::READY_LAT == 0 || ready_eff) begin
          // Present the beat as queued; fields whose option is off are driven as zero
          s_next.link.valid = ssd_pkg::USE_VALID;
          s_next.link.data  = tq_head.data;
          s_next.link.chan  = ssd_pkg::USE_CHANNEL ? tq_head.chan : '0;
          s_next.link.err   = ssd_pkg::USE_ERROR ? tq_head.err : '0;
          s_next.link.empty = (ssd_pkg::USE_PACKETS || ssd_pkg::USE_EMPTY)
                              ? tq_head.empty : '0;
          s_next.link.sop   = ssd_pkg::USE_PACKETS ? tq_head.sop : 1'b0;
          s_next.link.eop   = ssd_pkg::USE_PACKETS ? tq_head.eop : 1'b0;
          s_next.lat        = '0;
          s_next.ev.drive   = 1'b1;
          s_next.st         = SSD_SEND;
        end
      end
      SSD_SEND: begin
        if (tq_pop) begin
          s_next.link.valid = 1'b0;
          s_next.ev.done    = 1'b1;
          s_next.done       = 1'b1;
          s_next.st         = SSD_IDLE;
        end else begin
          // Beat fields held unchanged while waiting
          s_next.lat = s_reg.lat + 1'b1;
          if (resp_timeout != '0 && s_reg.lat + 1'b1 == resp_timeout) begin
            s_next.ev.timeout = 1'b1;
          end
        end
      end
      SSD_STOP: begin
        // Stopped: no beats and no events until reset
        s_next.link = '0;
        s_next.ev   = '0;
      end
      default: begin
        s_next.st = SSD_IDLE;
      end
    endcase
    if (init && s_reg.st != SSD_STOP) begin
      s_next.link     = '0;
      s_next.ev.drive = 1'b0;
      s_next.st       = SSD_IDLE;
    end
    if (fatal_req && s_reg.st != SSD_STOP) begin
      s_next.link     = '0;
      s_next.ev.fatal = 1'b1;
      s_next.ev.drive = 1'b0;
      s_next.st       = SSD_STOP;
    end
  end

  // Registers
  always_ff @(posedge clk) begin
    if (rst) begin
      s_reg    <= '0;
      s_reg.st <= SSD_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign link         = s_reg.link;
  assign events       = s_reg.ev;
  assign resp_latency = s_reg.last_lat;
  assign trans_done   = s_reg.done;
  assign halted       = (s_reg.st == SSD_STOP);

  // ****************************************************************
  // Checks
  // ****************************************************************
  chk_hold_beat: assert property (@(posedge clk) disable iff (rst)
    link.valid && !ready_eff && !init && !fatal_req |=> $stable(link))
    else $error("beat changed while waiting for ready");

  chk_drive_event: assert property (@(posedge clk) disable iff (rst)
    events.drive |-> link.valid)
    else $error("drive event without valid data");

  chk_ready_rise: assert property (@(posedge clk) disable iff (rst)
    $rose(ready_eff) |=> events.rdy_rise)
    else $error("ready rise event missing");

  chk_ready_fall: assert property (@(posedge clk) disable iff (rst)
    $fell(ready_eff) |=> events.rdy_fall)
    else $error("ready fall event missing");

  chk_done_pulse: assert property (@(posedge clk) disable iff (rst)
    events.done |-> trans_done && !link.valid)
    else $error("complete event without status");

  chk_stop_quiet: assert property (@(posedge clk) disable iff (rst)
    events.fatal |-> ##1 (!link.valid) [*4])
    else $error("activity after fatal error");

  chk_init_idle: assert property (@(posedge clk) disable iff (rst)
    init |=> !link.valid)
    else $error("init left link active");

  chk_count_push: assert property (@(posedge clk) disable iff (rst)
    push_trans && !trans_full && !tq_pop && !flush |=>
      trans_count == $past(trans_count) + 1'b1)
    else $error("queue count did not grow");

  chk_ready_sync: assert property (@(posedge clk) disable iff (rst)
    ssd_pkg::USE_READY && !$past(rst) && !$past(rst, 2) |->
      ready_now == $past(snk_ready, 2))
    else $error("ready view not two cycles behind pin");

  chk_halt_stays: assert property (@(posedge clk) disable iff (rst)
    halted |=> halted)
    else $error("left stop state without reset");

  chk_tmo_armed: assert property (@(posedge clk) disable iff (rst)
    events.timeout |-> $past(resp_timeout) != '0)
    else $error("timeout raised while disabled");

endmodule : ssd_source

// >>> tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;

`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin err_count++; \
  $display("unexpected %s expected %0h seen %0h", nm, exp, got); end end

  // ****************************************************************
  // Signals and instances
  // ****************************************************************
  logic                       clk, rst, init, field_we, push_trans, pop_resp;
  logic                       fatal_req, snk_ready, hold_off;
  ssd_pkg::ssd_field_e        field_sel;
  logic [ssd_pkg::DATA_W-1:0] field_val;
  ssd_pkg::ssd_lat_t          resp_timeout, resp_latency;
  ssd_pkg::ssd_link_s         link;
  ssd_pkg::ssd_events_s       events;
  logic [ssd_pkg::CNT_W-1:0]  trans_count, resp_count;
  logic                       ready_now, trans_done, halted, trans_full;
  int                         err_count = 0;
  int                         n_checks = 0;
  int                         n_rise = 0;
  int                         n_fall = 0;
  int                         n_tmo = 0;
  int                         n_fatal = 0;

  ssd_source i_dut (
    .clk(clk), .rst(rst), .init(init), .field_we(field_we), .field_sel(field_sel),
    .field_val(field_val), .push_trans(push_trans), .pop_resp(pop_resp),
    .resp_timeout(resp_timeout), .fatal_req(fatal_req), .snk_ready(snk_ready),
    .link(link), .events(events), .trans_count(trans_count), .resp_count(resp_count),
    .resp_latency(resp_latency), .ready_now(ready_now), .trans_done(trans_done),
    .halted(halted), .trans_full(trans_full)
  );

  ssd_sink_model i_sink (
    .clk(clk), .rst(rst), .link(link), .hold_off(hold_off), .snk_ready(snk_ready)
  );

  // Clock generator
  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end

  // Event pulse counters
  always @(posedge clk) begin
    if (rst === 1'h0) begin
      n_rise  += int'(events.rdy_rise === 1'h1);
      n_fall  += int'(events.rdy_fall === 1'h1);
      n_tmo   += int'(events.timeout === 1'h1);
      n_fatal += int'(events.fatal === 1'h1);
    end
  end

  // ****************************************************************
  // Drivers
  // ****************************************************************
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  task automatic set_f(input ssd_pkg::ssd_field_e s, input logic [31:0] v);
    field_we  = 1'h1;
    field_sel = s;
    field_val = v;
    cyc(1);
    field_we = 1'h0;
    cyc(1);
  endtask : set_f

  task automatic push1;
    push_trans = 1'h1;
    cyc(1);
    push_trans = 1'h0;
    cyc(1);
  endtask : push1

  task automatic pop1;
    pop_resp = 1'h1;
    cyc(1);
    pop_resp = 1'h0;
    cyc(1);
  endtask : pop1

  task automatic wait_valid(output int n);
    n = 0;
    while (link.valid !== 1'h1 && n < 64) begin
      cyc(1);
      n++;
    end
  endtask : wait_valid

  task final_report;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : final_report

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset;
    `CHK("idle valid", 1'h0, link.valid)
    `CHK("idle queue", 4'h0, trans_count)
    `CHK("idle resp", 4'h0, resp_count)
    `CHK("idle status", 1'h0, trans_done)
    `CHK("idle halt", 1'h0, halted)
    $display("test reset finished");
  endtask : t_reset

  task automatic t_xfer(input logic [31:0] d, input logic [15:0] idl);
    int n;
    int g0;
    g0 = i_sink.got.size();
    `CHK("ready bit high", 1'h1, ready_now)
    set_f(ssd_pkg::SSD_F_DATA, d);
    set_f(ssd_pkg::SSD_F_IDLES, {16'h0, idl});
    push1;
    `CHK("queued", 4'h1, trans_count)
    wait_valid(n);
    // One wait-state cycle always comes after the idles
    `CHK("lead cycles", 32'(idl) + 1, n)
    `CHK("drive event", 1'h1, events.drive)
    `CHK("data", d, link.data)
    cyc(1);
    `CHK("valid drop", 1'h0, link.valid)
    `CHK("done event", 1'h1, events.done)
    `CHK("done status", 1'h1, trans_done)
    `CHK("resp count", 4'h1, resp_count)
    `CHK("left count", 4'h0, trans_count)
    `CHK("sink beats", g0 + 1, i_sink.got.size())
    pop1;
    `CHK("latency", 32'h0, resp_latency)
    `CHK("resp empty", 4'h0, resp_count)
    $display("test xfer finished");
  endtask : t_xfer

  task automatic t_stall;
    int                 n;
    int                 f0;
    int                 r0;
    int                 t0;
    ssd_pkg::ssd_link_s held;
    f0 = n_fall;
    r0 = n_rise;
    t0 = n_tmo;
    resp_timeout = 32'h5;
    hold_off = 1'h1;
    cyc(5);
    `CHK("ready bit low", 1'h0, ready_now)
    `CHK("fall events", f0 + 1, n_fall)
    set_f(ssd_pkg::SSD_F_DATA, 32'h5a5a_c3c3);
    set_f(ssd_pkg::SSD_F_IDLES, 32'h0);
    push1;
    wait_valid(n);
    held = link;
    repeat (10) begin
      cyc(1);
      `CHK("held beat", held, link)
    end
    hold_off = 1'h0;
    n = 0;
    while (link.valid === 1'h1 && n < 16) begin
      cyc(1);
      n++;
    end
    `CHK("release cycles", 3, n)
    cyc(2);
    `CHK("rise events", r0 + 1, n_rise)
    `CHK("timeouts", t0 + 1, n_tmo)
    pop1;
    `CHK("stall latency", 32'hc, resp_latency)
    resp_timeout = 32'h0;
    $display("test stall finished");
  endtask : t_stall

  task automatic t_order;
    int n;
    int g0;
    g0 = i_sink.got.size();
    hold_off = 1'h1;
    cyc(5);
    set_f(ssd_pkg::SSD_F_SOP, 32'h1);
    set_f(ssd_pkg::SSD_F_EOP, 32'h1);
    set_f(ssd_pkg::SSD_F_EMPTY, 32'h2);
    for (int i = 0; i < 3; i++) begin
      set_f(ssd_pkg::SSD_F_DATA, 32'h1000_0000 + i);
      set_f(ssd_pkg::SSD_F_CHAN, i & 1);
      set_f(ssd_pkg::SSD_F_ERR, ~i & 1);
      push1;
    end
    `CHK("queue depth", 4'h3, trans_count)
    hold_off = 1'h0;
    n = 0;
    while (i_sink.got.size() < g0 + 3 && n < 64) begin
      cyc(1);
      n++;
    end
    cyc(3);
    for (int i = 0; i < 3; i++) begin
      `CHK("order data", 32'h1000_0000 + i, i_sink.got[g0 + i].data)
      `CHK("order chan", 1'(i & 1), i_sink.got[g0 + i].chan)
      `CHK("order err", 1'(~i & 1), i_sink.got[g0 + i].err)
      `CHK("sop option", ssd_pkg::USE_PACKETS, i_sink.got[g0 + i].sop)
    end
    `CHK("resp held", 4'h3, resp_count)
    repeat (3) pop1;
    `CHK("resp drained", 4'h0, resp_count)
    $display("test order finished");
  endtask : t_order

  task automatic t_init;
    int n;
    int g0;
    g0 = i_sink.got.size();
    hold_off = 1'h1;
    cyc(4);
    // Nine pushes against eight entries: the last one is refused
    push_trans = 1'h1;
    cyc(9);
    push_trans = 1'h0;
    wait_valid(n);
    `CHK("full flag", 1'h1, trans_full)
    `CHK("full queue", 4'h8, trans_count)
    init = 1'h1;
    cyc(1);
    init = 1'h0;
    cyc(1);
    `CHK("init valid", 1'h0, link.valid)
    `CHK("init queue", 4'h0, trans_count)
    hold_off = 1'h0;
    cyc(6);
    `CHK("init no beat", g0, i_sink.got.size())
    $display("test init finished");
  endtask : t_init

  task automatic t_fatal;
    int f0;
    f0 = n_fatal;
    fatal_req = 1'h1;
    cyc(1);
    fatal_req = 1'h0;
    cyc(3);
    `CHK("halted", 1'h1, halted)
    `CHK("fatal event", f0 + 1, n_fatal)
    push1;
    cyc(3);
    `CHK("after fatal queue", 4'h0, trans_count)
    `CHK("after fatal valid", 1'h0, link.valid)
    $display("test fatal finished");
  endtask : t_fatal

  // Watchdog against a hung handshake
  initial begin
    repeat (4000) @(posedge clk);
    err_count++;
    $display("unexpected watchdog expected finish seen hang");
    final_report;
  end

  // Main sequence
  initial begin
    rst = 1'h1;
    {init, field_we, push_trans, pop_resp, fatal_req, hold_off} = 6'h0;
    field_sel = ssd_pkg::SSD_F_DATA;
    field_val = 32'h0;
    resp_timeout = 32'h0;
    repeat (16) @(negedge clk);
    rst = 1'h0;
    cyc(8);
    t_reset;
    t_xfer(32'ha5c3_0f01, 16'h0);
    t_xfer(32'h0ff0_1234, 16'h3);
    t_stall;
    t_order;
    t_init;
    t_fatal;
    final_report;
  end
endmodule : tb
